/* dma_pins_agent.sv */
`timescale 1ns/1ps
module dma_pins_agent (
  input wire logic mclk,
  input wire logic rst_b,
  dma_pins_if.agent pins,
  input wire logic req_active_low,
  input wire logic dack_active_low,
  input wire logic [dma_pins_pkg::num_isa_ch-1:0] want_isa,
  input wire logic [dma_pins_pkg::num_pcpci_ch-1:0] want_pci,
  output logic [dma_pins_pkg::num_isa_ch-1:0] master_ok,
  output logic [dma_pins_pkg::num_pcpci_ch-1:0] pci_granted,
  output logic tc_seen
);
  import dma_pins_pkg::*;

  logic [num_isa_ch-1:0] hold_q, hold_d;
  logic [num_isa_ch-1:0] ack_act;
  logic [num_pcpci_ch-1:0] preq_q, preq_d;

  // Request is held until acknowledged, even if the user drops want meanwhile.
  always_comb begin
    ack_act = pins.dack ^ {num_isa_ch{dack_active_low}};
    hold_d = (hold_q | want_isa) & ~ack_act;
    preq_d = want_pci;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
      preq_q <= '0;
    end else begin
      hold_q <= hold_d;
      preq_q <= preq_d;
    end
  end

  assign pins.dreq = (hold_q | ack_act & want_isa) ^ {num_isa_ch{req_active_low}};
  assign pins.pcpci_req_b = ~preq_q;
  assign master_ok = ack_act;
  assign pci_granted = ~pins.pcpci_gnt_b;
  assign tc_seen = pins.tc;
endmodule // dma_pins_agent

/* dma_pins_assertions.sv */
`timescale 1ns/1ps
module dma_pins_assertions (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] dreq,
  input wire logic [7:0] dack,
  input wire logic tc,
  input wire logic aen,
  input wire logic [2:0] pcpci_req_b,
  input wire logic [2:0] pcpci_gnt_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Fixed polarity only: acknowledge active low, request active high.
  property p_rst; $rose(rst_b) |-> dack == 8'hff && !tc; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_one; $onehot0(~dack) && dack[4]; endproperty
  a_one: assert property (p_one) else $error("bad dack");
  property p_aen; dack != 8'hff |-> aen; endproperty
  a_aen: assert property (p_aen) else $error("no aen");
  property p_req; (~dack & $past(dack) & ~$past(dreq, 3)) == 8'h0; endproperty
  a_req: assert property (p_req) else $error("early dack");
  property p_sync; $rose(dreq[0]) |=> dack[0] [*2]; endproperty
  a_sync: assert property (p_sync) else $error("fast dack");
  // Autoinit keeps the grant, so either the grant ends or the count flag is withdrawn first.
  property p_tcr; $rose(tc) |-> aen ##1 (!aen || !tc); endproperty
  a_tcr: assert property (p_tcr) else $error("bad tc");
  property p_tcf; $fell(tc) |-> !$past(aen) || aen; endproperty
  a_tcf: assert property (p_tcf) else $error("tc early");
  property p_gnt; (~pcpci_gnt_b & $past(pcpci_gnt_b) & $past(pcpci_req_b, 3)) == 3'h0; endproperty
  a_gnt: assert property (p_gnt) else $error("bad gnt");
  c_tc: cover property ($rose(tc));
  c_isa: cover property ($fell(aen));
  c_pci: cover property ($fell(pcpci_gnt_b[2]));
endmodule // dma_pins_assertions

/* dma_pins_device.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Assert channel acknowledge when service granted.
// - Acknowledge and request polarity are selectable.
// - Slave decodes acknowledge with read/write strobe.
// - Master waits for acknowledge before taking bus.
// - No acknowledge if request drops first.
// - Acknowledge pins high during and after reset; here they sit at the dack_active_low level, or high while suspend is set.
// - Request edges treated as asynchronous.
// - Agent holds request until acknowledged.
// - PCI agents request on three active-low inputs.
// - Matching active-low grant acknowledges PCI request.
// - Unused request/grant pins become spare inputs/outputs.
// - Terminal count asserted when count expires.
// - Terminal count held until AEN negates; autoinit earlier.
// - Terminal count low during and after reset.
module dma_pins_device (
  input wire logic mclk,
  input wire logic rst_b,
  dma_pins_if.device pins,
  input wire logic req_active_low,
  input wire logic dack_active_low,
  input wire logic suspend,
  input wire logic pcpci_enable,
  input wire logic [dma_pins_pkg::num_isa_ch-1:0] ch_enable,
  input wire logic xfer_done,
  input wire logic count_expired,
  input wire logic autoinit,
  input wire logic [dma_pins_pkg::num_pcpci_ch-1:0] spare_output_9_to_11,
  output logic [dma_pins_pkg::num_pcpci_ch-1:0] spare_input_2_to_4,
  output logic [2:0] grant_ch,
  output logic grant_valid,
  output logic [1:0] pcpci_grant_ch,
  output logic pcpci_grant_valid
);
  import dma_pins_pkg::*;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_isa = 3'b010,
    st_pci = 3'b100
  } state_t;

  state_t state_q, state_d;
  logic [2:0] ch_q, ch_d;
  logic [1:0] pch_q, pch_d;
  logic tc_q, tc_d;
  logic aen_q, aen_d;
  logic [num_isa_ch-1:0] s1_q, s2_q, s3_q, req_q;
  logic [num_pcpci_ch-1:0] p1_q, p2_q, p3_q, preq_q;
  logic [num_isa_ch-1:0] req_raw;
  logic [num_isa_ch-1:0] dack_act;
  logic [num_pcpci_ch-1:0] gnt_act;
  logic [num_isa_ch-1:0] req_live;

  // Three stages; a level counts only when the last two agree, so one glitchy sample is ignored.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      req_q <= '0;
      p1_q <= '1;
      p2_q <= '1;
      p3_q <= '1;
      preq_q <= '1;
    end else begin
      s1_q <= pins.dreq;
      s2_q <= s1_q;
      s3_q <= s2_q;
      p1_q <= pins.pcpci_req_b;
      p2_q <= p1_q;
      p3_q <= p2_q;
      for (int i = 0; i < num_isa_ch; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          req_q[i] <= s3_q[i];
        end
      end
      for (int i = 0; i < num_pcpci_ch; i++) begin
        if (p2_q[i] == p3_q[i]) begin
          preq_q[i] <= p3_q[i];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < num_isa_ch; g++) begin : g_req
      assign req_raw[g] = req_q[g] ^ req_active_low;
      assign req_live[g] = req_raw[g] & ch_enable[g] & isa_ch_present[g];
      assign dack_act[g] = (state_q == st_isa) && (ch_q == 3'(g));
      // Inactive level is high when active-low; suspend forces the reset level.
      assign pins.dack[g] = suspend ? dack_rst_level : (dack_act[g] ^ dack_active_low);
    end
    for (g = 0; g < num_pcpci_ch; g++) begin : g_gnt
      assign gnt_act[g] = (state_q == st_pci) && (pch_q == 2'(g));
      assign pins.pcpci_gnt_b[g] = suspend ? gnt_rst_level :
        (pcpci_enable ? ~gnt_act[g] : spare_output_9_to_11[g]);
    end
  endgenerate

  assign spare_input_2_to_4 = preq_q;
  assign pins.tc = suspend ? tc_rst_level : tc_q;
  assign pins.aen = aen_q;
  assign grant_ch = ch_q;
  assign grant_valid = (state_q == st_isa);
  assign pcpci_grant_ch = pch_q;
  assign pcpci_grant_valid = (state_q == st_pci);

  // Fixed priority, lowest channel first; rotation is left to the channel engines.
  always_comb begin
    state_d = state_q;
    ch_d = ch_q;
    pch_d = pch_q;
    tc_d = tc_q;
    aen_d = aen_q;
    case (state_q)
      st_idle: begin
        tc_d = 1'b0;
        aen_d = 1'b0;
        if (!suspend) begin
          if (|req_live) begin
            for (int i = num_isa_ch - 1; i >= 0; i--) begin
              if (req_live[i]) begin
                ch_d = 3'(i);
              end
            end
            state_d = st_isa;
            aen_d = 1'b1;
          end else if (pcpci_enable && !(&preq_q)) begin
            for (int i = num_pcpci_ch - 1; i >= 0; i--) begin
              if (!preq_q[i]) begin
                pch_d = 2'(i);
              end
            end
            state_d = st_pci;
          end
        end
      end
      st_isa: begin
        // With autoinit the count is flagged for one cycle and withdrawn while the grant still stands.
        if (xfer_done && count_expired) begin
          tc_d = 1'b1;
        end
        if (tc_q && autoinit) begin
          tc_d = 1'b0;
        end else if (tc_q || !req_raw[ch_q] || suspend) begin
          state_d = st_idle;
          aen_d = 1'b0;
          tc_d = tc_q && !autoinit;
        end
      end
      st_pci: begin
        if (preq_q[pch_q] || !pcpci_enable || suspend) begin
          state_d = st_idle;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_idle;
      ch_q <= no_channel;
      pch_q <= 2'h0;
      tc_q <= tc_rst_level;
      aen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ch_q <= ch_d;
      pch_q <= pch_d;
      tc_q <= tc_d;
      aen_q <= aen_d;
    end
  end
endmodule // dma_pins_device

/* dma_pins_if.sv */
`timescale 1ns/1ps
interface dma_pins_if;
  import dma_pins_pkg::*;
  logic [num_isa_ch-1:0] dreq;
  logic [num_isa_ch-1:0] dack;
  logic tc;
  logic aen;
  logic [num_pcpci_ch-1:0] pcpci_req_b;
  logic [num_pcpci_ch-1:0] pcpci_gnt_b;
  modport device (
    input dreq,
    output dack,
    output tc,
    output aen,
    input pcpci_req_b,
    output pcpci_gnt_b
  );
  modport agent (
    output dreq,
    input dack,
    input tc,
    input aen,
    output pcpci_req_b,
    input pcpci_gnt_b
  );
endinterface

/* dma_pins_pkg.sv */
package dma_pins_pkg;
  localparam int num_isa_ch = 8;
  localparam int num_pcpci_ch = 3;
  localparam logic [7:0] isa_ch_present = 8'hef;
  localparam logic dack_rst_level = 1'b1;
  localparam logic tc_rst_level = 1'b0;
  localparam logic gnt_rst_level = 1'b1;
  localparam logic polarity_rst = 1'b0;
  localparam logic [2:0] no_channel = 3'h4;
endpackage

/* tb_isa_dma_request_grant_pins.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("Error %0t: mismatch", $time); end end
module tb_isa_dma_request_grant_pins;
  import dma_pins_pkg::*;
  logic mclk = 0, rst_b = 0, suspend = 0, pcpci_enable = 1, xfer_done = 0, count_expired = 0, autoinit = 0;
  logic gv, gv_q = 0, tcs, pgv;
  logic [7:0] wi = 0, ch_enable = 8'hff, ok;
  logic [2:0] wp = 0, so = 3'h7, si, ch, e, okp;
  logic [1:0] pch;
  logic [31:0] r = 32'h263567ad;
  logic [2:0] exp_q[$];
  int errors = 0, tests_run = 0, cyc = 0;
  dma_pins_if pins ();
  dma_pins_device dma_pins_device_inst (.mclk, .rst_b, .pins(pins.device), .req_active_low(1'b0),
    .dack_active_low(1'b1), .suspend, .pcpci_enable, .ch_enable, .xfer_done, .count_expired, .autoinit,
    .spare_output_9_to_11(so), .spare_input_2_to_4(si), .grant_ch(ch), .grant_valid(gv), .pcpci_grant_ch(pch),
    .pcpci_grant_valid(pgv));
  dma_pins_agent dma_pins_agent_inst (.mclk, .rst_b, .pins(pins.agent), .req_active_low(1'b0),
    .dack_active_low(1'b1), .want_isa(wi), .want_pci(wp), .master_ok(ok), .pci_granted(okp), .tc_seen(tcs));
  dma_pins_assertions dma_pins_assertions_inst (.mclk, .rst_b, .dreq(pins.dreq), .dack(pins.dack), .tc(pins.tc),
    .aen(pins.aen), .pcpci_req_b(pins.pcpci_req_b), .pcpci_gnt_b(pins.pcpci_gnt_b));
  function automatic logic [31:0] next_r(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic grant(input logic [2:0] g);
    exp_q.push_back(g);
    wi[g] = 1'b1;
    for (int i = 0; i < 20 && ok[g] !== 1'b1; i++) tick(1);
  endtask
  task automatic xfer(input logic x);
    count_expired = x;
    xfer_done = 1'b1;
    tick(1);
    `CHK(tcs, x)
    xfer_done = 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 20000) begin
    errors++;
    give_verdict();
  end
  always @(negedge mclk) begin
    if (gv === 1'b1 && gv_q !== 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : no_channel;
      `CHK(ch, e)
    end
    gv_q <= gv;
  end
  initial begin
    tick(2);
    `CHK(pins.dack, 8'hff)
    rst_b = 1'b1;
    tick(1);
    `CHK({pins.dack, pins.tc, pins.pcpci_gnt_b}, 12'hff7)
    // A one-cycle want must still be held on the pin until acknowledged.
    wi[0] = 1'b1;
    exp_q.push_back(3'h0);
    tick(1);
    wi[0] = 1'b0;
    for (int i = 0; i < 20 && ok[0] !== 1'b1; i++) tick(1);
    `CHK(ok[0], 1'b1)
    tick(8);
    `CHK(ok, 8'h0)
    $display("Reset test done");
    for (int n = 0; n < 6; n++) begin
      r = next_r(r);
      autoinit = r[3];
      grant(r[2:0] == 3'h4 ? 3'h5 : r[2:0]);
      `CHK(pins.aen, 1'b1)
      xfer(1'b0);
      `CHK(tcs, 1'b0)
      xfer(1'b1);
      `CHK(tcs, ~autoinit)
      // Masking stops a regrant while the filtered request is still draining.
      wi = 8'h0;
      ch_enable = 8'h0;
      tick(8);
      `CHK(pins.tc, 1'b0)
      ch_enable = 8'hff;
    end
    grant(3'h5);
    // The agent must register the acknowledge before suspend hides it, or it keeps requesting.
    tick(1);
    suspend = 1'b1;
    wi = 8'h0;
    ch_enable = 8'h0;
    tick(1);
    `CHK({pins.dack, pins.tc, pins.pcpci_gnt_b}, 12'hff7)
    suspend = 1'b0;
    tick(8);
    ch_enable = 8'hff;
    $display("Grant test done");
    for (int k = 0; k < 3; k++) begin
      wp = 3'h1 << k;
      for (int i = 0; i < 20 && okp[k] !== 1'b1; i++) tick(1);
      `CHK({pch, pins.pcpci_gnt_b, pgv}, {2'(k), ~wp, 1'b1})
      wp = 3'h0;
      tick(8);
    end
    pcpci_enable = 1'b0;
    wp = 3'h7;
    tick(6);
    so = 3'h5;
    tick(2);
    `CHK({pins.pcpci_gnt_b, si}, 6'h28)
    $display("Request pin test done");
    give_verdict();
  end
endmodule // tb_isa_dma_request_grant_pins
